// ===== core/ldc_pkg.sv
`default_nettype none
package ldc_pkg;
    // Geometry of the driver.
    localparam int LDC_NUM_LEDS = 6;
    localparam int LDC_CODE_W   = 6;
    localparam int LDC_ADDR_W   = 4;
    localparam int LDC_DATA_W   = 8;

    // Register offsets.
    localparam logic [3:0] LDC_ADDR_GP     = 4'h0;
    localparam logic [3:0] LDC_ADDR_GROUP  = 4'h1;
    localparam logic [3:0] LDC_ADDR_RAMP   = 4'h2;
    localparam logic [3:0] LDC_ADDR_BRT_A  = 4'h3;
    localparam logic [3:0] LDC_ADDR_BRT_B  = 4'h4;
    localparam logic [3:0] LDC_ADDR_STATUS = 4'h8;

    // Field positions and reset values.
    localparam int         LDC_GP_PWM_BIT = 7;
    localparam logic [7:0] LDC_RST_GP     = 8'h00;
    localparam logic [5:0] LDC_RST_GROUP  = 6'h03;
    localparam logic [5:0] LDC_GROUP_FIX  = 6'h03;
    localparam logic [1:0] LDC_RST_RAMP   = 2'h0;
    localparam logic [5:0] LDC_RST_CODE   = 6'h00;

    // Ramp step times in microseconds, and the clock rate.
    localparam int LDC_CLK_MHZ     = 10;
    localparam int LDC_STEP0_US    = 100;
    localparam int LDC_STEP1_US    = 25000;
    localparam int LDC_STEP2_US    = 50000;
    localparam int LDC_STEP3_US    = 100000;
    localparam int LDC_RAMP_CNT_W  = 20;

    // Sink drive handed to the analog current sinks.
    typedef struct packed {
        logic [5:0]  on;
        logic [35:0] code;
    } ldc_drive_type;
endpackage
`default_nettype wire

// ===== core/ldc_core.sv
// Functional notes
// - Each sink takes one of 64 exponentially spaced levels from a code.
// - Reset leaves five banks, 2,1,1,1,1; LEDs 0 and 1 are primary.
// - Host may move LEDs 2 to 5 into the primary group.
// - Pump stays 1x until regulation is lost, then goes 1.5x.
// - In 1.5x the pump returns to 1x when cathodes exceed 1.8V.
// - With mode bit 7 clear the enable pin is a chip enable.
// - Enable low in enable mode disables all and resets registers.
// - Enable high opens the bus; LEDs switch from the general register.
// - Bus access works whether LEDs are lit or dark.
// - Writing bit 7 as one makes the pin a PWM dimming input.
// - In PWM mode current flows only while the pin is high.
// - PWM gating applies on top of the register brightness code.
// - Current is a code fraction of a fixed full scale.
// - Primary brightness ramps one code per step, step time by 2 bits.
`timescale 1ns/1ps
`default_nettype none
module ldc_core
    import ldc_pkg::*;
#(
    parameter int STEP0_CYC = LDC_STEP0_US * LDC_CLK_MHZ,
    parameter int STEP1_CYC = LDC_STEP1_US * LDC_CLK_MHZ,
    parameter int STEP2_CYC = LDC_STEP2_US * LDC_CLK_MHZ,
    parameter int STEP3_CYC = LDC_STEP3_US * LDC_CLK_MHZ
)
(
    // Clocks and reset
    input  wire logic                  ref_clk,
    input  wire logic                  drv_clk,
    input  wire logic                  rst_n,
    // Register port
    input  wire logic [LDC_ADDR_W-1:0] reg_addr,
    input  wire logic [LDC_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [LDC_DATA_W-1:0] reg_rdata,
    // Enable pin and pump comparators
    input  wire logic                  en_pwm_pin,
    input  wire logic                  highest_forward_voltage_lost,
    input  wire logic                  cathode_above_min,
    // Sink and pump drive
    output var ldc_drive_type          led_drive,
    output logic                       pump_boost,
    output logic                       chip_active
);

    localparam logic [19:0] MAX_CYC = 20'hFFFFF;

    // Step counts must fit the ramp counter and be at least one cycle.
    if (STEP0_CYC < 1 || STEP1_CYC < 1 || STEP2_CYC < 1 || STEP3_CYC < 1 ||
        STEP0_CYC > MAX_CYC || STEP1_CYC > MAX_CYC ||
        STEP2_CYC > MAX_CYC || STEP3_CYC > MAX_CYC)
    begin : g_bad_step
        $error("ldc_core: ramp step count out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable pin synchroniser in the register domain.

    logic en_meta_reg;
    logic en_sync_reg;

    // The pin is asynchronous, so it passes two flops before anything.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_meta_reg <= 1'b0;
            en_sync_reg <= 1'b0;
        end
        else
        begin
            en_meta_reg <= en_pwm_pin;
            en_sync_reg <= en_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [7:0] gp_reg;
    logic [7:0] gp_next;
    logic [5:0] group_reg;
    logic [5:0] group_next;
    logic [1:0] ramp_reg;
    logic [1:0] ramp_next;
    logic [5:0] brt_reg [5];
    logic [5:0] brt_next [5];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       pwm_mode;
    logic       active;
    logic       boost_ref_reg;
    logic [5:0] cur_reg;
    logic       busy;

    assign pwm_mode = gp_reg[LDC_GP_PWM_BIT];
    // In enable mode a low pin holds everything cleared; in PWM mode the
    // pin only gates current, so the interface stays alive.
    assign active = pwm_mode | en_sync_reg;
    assign busy = (cur_reg != brt_reg[0]);

    // Bus writes, the soft clear from the enable pin, and read data.
    always_comb
    begin
        gp_next    = gp_reg;
        group_next = group_reg;
        ramp_next  = ramp_reg;
        rdata_next = 8'h00;
        for (int i = 0; i < 5; i++)
        begin
            brt_next[i] = brt_reg[i];
        end
        if (!active)
        begin
            // Everything returns to defaults; the bus is shut.
            gp_next    = LDC_RST_GP;
            group_next = LDC_RST_GROUP;
            ramp_next  = LDC_RST_RAMP;
            for (int i = 0; i < 5; i++)
            begin
                brt_next[i] = LDC_RST_CODE;
            end
        end
        else
        begin
            // Accepted regardless of which LEDs are lit.
            if (reg_wr)
            begin
                unique case (reg_addr)
                    LDC_ADDR_GP:    gp_next = reg_wdata;
                    // LEDs 0 and 1 can never leave the primary group.
                    LDC_ADDR_GROUP: group_next = reg_wdata[5:0] |
                                                 LDC_GROUP_FIX;
                    LDC_ADDR_RAMP:  ramp_next = reg_wdata[1:0];
                    default:
                    begin
                        if (reg_addr >= LDC_ADDR_BRT_A &&
                            reg_addr <  LDC_ADDR_STATUS)
                        begin
                            brt_next[3'(reg_addr - LDC_ADDR_BRT_A)] =
                                reg_wdata[5:0];
                        end
                    end
                endcase
            end
            if (reg_rd)
            begin
                unique case (reg_addr)
                    LDC_ADDR_GP:     rdata_next = gp_reg;
                    LDC_ADDR_GROUP:  rdata_next = {2'h0, group_reg};
                    LDC_ADDR_RAMP:   rdata_next = {6'h00, ramp_reg};
                    LDC_ADDR_STATUS: rdata_next = {boost_ref_reg, busy,
                                                   cur_reg};
                    default:
                    begin
                        if (reg_addr >= LDC_ADDR_BRT_A &&
                            reg_addr <  LDC_ADDR_STATUS)
                        begin
                            rdata_next = {2'h0,
                                brt_reg[3'(reg_addr - LDC_ADDR_BRT_A)]};
                        end
                    end
                endcase
            end
        end
    end

    // Reset puts the banks in their 2,1,1,1,1 arrangement.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gp_reg    <= LDC_RST_GP;
            group_reg <= LDC_RST_GROUP;
            ramp_reg  <= LDC_RST_RAMP;
            rdata_reg <= 8'h00;
            for (int i = 0; i < 5; i++)
            begin
                brt_reg[i] <= LDC_RST_CODE;
            end
        end
        else
        begin
            gp_reg    <= gp_next;
            group_reg <= group_next;
            ramp_reg  <= ramp_next;
            rdata_reg <= rdata_next;
            for (int i = 0; i < 5; i++)
            begin
                brt_reg[i] <= brt_next[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Primary group brightness ramp.

    logic [19:0] cnt_reg;
    logic [19:0] cnt_next;
    logic [5:0]  cur_next;
    logic [19:0] step_cyc;

    always_comb
    begin
        unique case (ramp_reg)
            2'h0: step_cyc = 20'(STEP0_CYC);
            2'h1: step_cyc = 20'(STEP1_CYC);
            2'h2: step_cyc = 20'(STEP2_CYC);
            2'h3: step_cyc = 20'(STEP3_CYC);
        endcase
    end

    // One code per step walks the exponential table without jumps.
    always_comb
    begin
        cnt_next = cnt_reg;
        cur_next = cur_reg;
        if (!active)
        begin
            cnt_next = 20'h00000;
            cur_next = LDC_RST_CODE;
        end
        else if (!busy)
        begin
            cnt_next = 20'h00000;
        end
        else if (cnt_reg >= step_cyc - 20'h00001)
        begin
            cnt_next = 20'h00000;
            cur_next = (cur_reg < brt_reg[0]) ? cur_reg + 6'h01
                                              : cur_reg - 6'h01;
        end
        else
        begin
            cnt_next = cnt_reg + 20'h00001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= 20'h00000;
            cur_reg <= LDC_RST_CODE;
        end
        else
        begin
            cnt_reg <= cnt_next;
            cur_reg <= cur_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sink drive. Full scale is fixed in the analog sink, so only the
    // monotonic code leaves here; zero still gives the lowest current.

    ldc_drive_type drive_next;
    ldc_drive_type drive_reg;
    logic          gate;

    // PWM mode gates the current while the code stays in force.
    assign gate = pwm_mode ? en_sync_reg : 1'b1;

    always_comb
    begin
        drive_next = '0;
        for (int i = 0; i < LDC_NUM_LEDS; i++)
        begin
            drive_next.on[i] = active & gate & gp_reg[i];
            drive_next.code[6*i +: 6] = group_reg[i] ? cur_reg
                : brt_reg[(i < 2) ? 0 : i - 1];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drive_reg <= '0;
        end
        else
        begin
            drive_reg <= drive_next;
        end
    end

    assign led_drive   = drive_reg;
    assign reg_rdata   = rdata_reg;
    assign chip_active = en_sync_reg;

    ////////////////////////////////////////////////////////////////////////
    // Charge-pump mode in the oscillator domain.

    logic act_src_reg;
    logic act_meta_reg;
    logic act_sync_reg;
    logic lost_meta_reg;
    logic lost_sync_reg;
    logic above_meta_reg;
    logic above_sync_reg;
    logic boost_reg;
    logic boost_next;

    // Comparators and the active level cross on two flops each.
    always_ff @(posedge drv_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_meta_reg   <= 1'b0;
            act_sync_reg   <= 1'b0;
            lost_meta_reg  <= 1'b0;
            lost_sync_reg  <= 1'b0;
            above_meta_reg <= 1'b0;
            above_sync_reg <= 1'b0;
        end
        else
        begin
            act_meta_reg   <= act_src_reg;
            act_sync_reg   <= act_meta_reg;
            lost_meta_reg  <= highest_forward_voltage_lost;
            lost_sync_reg  <= lost_meta_reg;
            above_meta_reg <= cathode_above_min;
            above_sync_reg <= above_meta_reg;
        end
    end

    // Hysteresis between the two thresholds keeps the pump from chattering.
    always_comb
    begin
        boost_next = boost_reg;
        if (!act_sync_reg)
        begin
            boost_next = 1'b0;
        end
        else if (!boost_reg && lost_sync_reg)
        begin
            boost_next = 1'b1;
        end
        else if (boost_reg && above_sync_reg)
        begin
            boost_next = 1'b0;
        end
    end

    always_ff @(posedge drv_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boost_reg <= 1'b0;
        end
        else
        begin
            boost_reg <= boost_next;
        end
    end

    assign pump_boost = boost_reg;

    logic boost_meta_reg;

    // Pump mode comes back for the status register over two flops. The
    // active level leaves from a flop, since a glitch of the OR could
    // otherwise be caught in the oscillator domain.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_src_reg    <= 1'b0;
            boost_meta_reg <= 1'b0;
            boost_ref_reg  <= 1'b0;
        end
        else
        begin
            act_src_reg    <= active;
            boost_meta_reg <= boost_reg;
            boost_ref_reg  <= boost_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    a_disable_clears: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !active |=> (gp_reg == LDC_RST_GP) && (brt_reg[0] == LDC_RST_CODE)
                    && (led_drive.on == 6'h00))
        else $error("registers not cleared while disabled");

    a_pwm_gates_off: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (pwm_mode && !en_sync_reg) |=> (led_drive.on == 6'h00))
        else $error("current flows with PWM pin low");

    a_primary_fixed: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        group_reg[1:0] == 2'b11)
        else $error("LED 0 or 1 left the primary group");

    a_ramp_one_step: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ($past(active) && active && cur_reg != $past(cur_reg)) |->
        (cur_reg == $past(cur_reg) + 6'h01 ||
         cur_reg == $past(cur_reg) - 6'h01))
        else $error("ramp moved more than one code");

    a_gp_write_kept: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (active && reg_wr && reg_addr == LDC_ADDR_GP && reg_wdata[7]) |=>
        gp_reg == $past(reg_wdata))
        else $error("general register write lost");

    a_code_follows: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ##1 led_drive.code[5:0] == $past(cur_reg))
        else $error("primary code not driven");

    a_pump_up: assert property (
        @(posedge drv_clk) disable iff (!rst_n)
        (act_sync_reg && !boost_reg && lost_sync_reg) |=> boost_reg)
        else $error("pump did not enter 1.5x");

    a_pump_down: assert property (
        @(posedge drv_clk) disable iff (!rst_n)
        (boost_reg && above_sync_reg) |=> !boost_reg)
        else $error("pump did not return to 1x");

endmodule
`default_nettype wire

// ===== bench/ldc_pump_model.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_pump_model
(
    // Clock and reset
    input  wire logic drv_clk,
    input  wire logic rst_n,
    // Conditions commanded by the bench
    input  wire logic want_lost,
    input  wire logic want_above,
    // Comparator levels seen by the pump logic
    output logic      cmp_lost,
    output logic      cmp_above
);
    logic lost_reg;
    logic lost_next;
    logic above_reg;
    logic above_next;

    // Comparators follow the commanded sink state one clock late.
    always_comb
    begin
        lost_next  = want_lost;
        above_next = want_above;
    end

    // Registered so that levels move only just after an oscillator edge.
    always_ff @(posedge drv_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lost_reg  <= 1'b0;
            above_reg <= 1'b0;
        end
        else
        begin
            lost_reg  <= lost_next;
            above_reg <= above_next;
        end
    end

    assign cmp_lost  = lost_reg;
    assign cmp_above = above_reg;
endmodule
`default_nettype wire

// ===== bench/ldc_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_core_test;
    import ldc_pkg::*;
    localparam int S0 = 4;
    localparam int S1 = 6;
    localparam int S2 = 8;
    localparam int S3 = 10;
    logic          ref_clk;
    logic          drv_clk;
    logic          rst_n;
    logic [3:0]    reg_addr;
    logic [7:0]    reg_wdata;
    logic          reg_wr;
    logic          reg_rd;
    logic [7:0]    reg_rdata;
    logic          en_pwm_pin;
    logic          want_lost;
    logic          want_above;
    logic          cmp_lost;
    logic          cmp_above;
    ldc_drive_type led_drive;
    logic          pump_boost;
    logic          chip_active;
    logic          rd_seen;
    logic [15:0]   notes[$];
    logic [15:0]   note;
    logic [31:0]   rnd;
    logic [5:0]    code[4];
    int            fails;
    int            checks_done;
    int            cycles;
    int            st;

    ldc_core #(.STEP0_CYC(S0), .STEP1_CYC(S1), .STEP2_CYC(S2), .STEP3_CYC(S3))
    u_ldc_core (.ref_clk(ref_clk), .drv_clk(drv_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .en_pwm_pin(en_pwm_pin),
        .highest_forward_voltage_lost(cmp_lost),
        .cathode_above_min(cmp_above), .led_drive(led_drive),
        .pump_boost(pump_boost), .chip_active(chip_active));

    ldc_pump_model u_ldc_pump_model (.drv_clk(drv_clk), .rst_n(rst_n),
        .want_lost(want_lost), .want_above(want_above),
        .cmp_lost(cmp_lost), .cmp_above(cmp_above));

    // Two unrelated clocks; the oscillator starts off phase on purpose.
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial
    begin
        drv_clk = 1'b0;
        #7;
        forever #24 drv_clk = ~drv_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [41:0] got, input logic [41:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // A read notes its expected byte and mask for the monitor.
    task automatic rd(input logic [3:0] a, input logic [7:0] e,
                      input logic [7:0] m);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        notes.push_back({m, e});
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Read data stand only in the cycle after the strobe, so look mid-cycle.
    always @(posedge ref_clk)
        rd_seen <= reg_rd;
    always @(negedge ref_clk)
    begin
        if (rd_seen === 1'b1)
        begin
            note = notes.pop_front();
            chk(42'(reg_rdata & note[15:8]),
                42'(note[7:0] & note[15:8]));
        end
    end

    // A hang is cut short well beyond the expected run length.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            test_done();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        en_pwm_pin = 1'b1;
        want_lost = 1'b0;
        want_above = 1'b0;
        rd_seen = 1'b0;
        rnd = 32'hDD8B;
        wait_cyc(4);
        rst_n <= 1'b1;
        wait_cyc(4);
        rd(LDC_ADDR_GP, 8'h00, 8'hFF);
        rd(LDC_ADDR_GROUP, 8'h03, 8'hFF);
        rd(LDC_ADDR_RAMP, 8'h00, 8'hFF);
        rd(LDC_ADDR_BRT_A, 8'h00, 8'hFF);
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00, 8'hFF);
        wr(LDC_ADDR_RAMP, 8'hFC);
        rd(LDC_ADDR_RAMP, 8'h00, 8'hFF);
        // Independent banks take random codes.
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            code[i] = rnd[5:0];
            wr(4'(LDC_ADDR_BRT_B + i), {2'b00, code[i]});
            rd(4'(LDC_ADDR_BRT_B + i), {2'b00, code[i]}, 8'hFF);
        end
        wr(LDC_ADDR_GP, 8'h3F);
        wait_cyc(3);
        chk(42'({chip_active, led_drive.on}), 42'h7F);
        chk(42'(led_drive.code),
            42'({code[3], code[2], code[1], code[0], 12'h0}));
        // Primary ramp: busy at first, target reached after three steps.
        wr(LDC_ADDR_BRT_A, 8'h03);
        rd(LDC_ADDR_STATUS, 8'h40, 8'h40);
        wait_cyc(3 * S0 + 6);
        rd(LDC_ADDR_STATUS, 8'h03, 8'hFF);
        chk(42'(led_drive.code[11:0]), 42'h0C3);
        wr(LDC_ADDR_GROUP, 8'h04);
        rd(LDC_ADDR_GROUP, 8'h07, 8'hFF);
        wait_cyc(3);
        chk(42'(led_drive.code[23:12]), {30'h0, code[1], 6'h03});
        wr(LDC_ADDR_GROUP, 8'h3F);
        wait_cyc(3);
        chk(42'(led_drive.code), 42'({6{6'h03}}));
        // Pin as a gate: registers survive, code stays under the gate.
        wr(LDC_ADDR_GP, 8'hBF);
        en_pwm_pin <= 1'b0;
        wait_cyc(4);
        chk(42'(led_drive.on), 42'h00);
        chk(42'(led_drive.code), 42'({6{6'h03}}));
        rd(LDC_ADDR_GP, 8'hBF, 8'hFF);
        en_pwm_pin <= 1'b1;
        wait_cyc(4);
        chk(42'(led_drive.on), 42'h3F);
        // Pump gain follows the comparators, with hysteresis.
        want_lost <= 1'b1;
        wait_cyc(12);
        chk(42'(pump_boost), 42'h1);
        rd(LDC_ADDR_STATUS, 8'h80, 8'h80);
        want_lost <= 1'b0;
        wait_cyc(12);
        chk(42'(pump_boost), 42'h1);
        want_above <= 1'b1;
        wait_cyc(12);
        chk(42'(pump_boost), 42'h0);
        want_above <= 1'b0;
        // Back to chip enable; a low pin then clears everything.
        wr(LDC_ADDR_GP, 8'h3F);
        en_pwm_pin <= 1'b0;
        wait_cyc(6);
        chk(42'({chip_active, led_drive.on}), 42'h0);
        rd(LDC_ADDR_GP, 8'h00, 8'hFF);
        en_pwm_pin <= 1'b1;
        wait_cyc(4);
        rd(LDC_ADDR_GP, 8'h00, 8'hFF);
        rd(LDC_ADDR_GROUP, 8'h03, 8'hFF);
        rd(LDC_ADDR_BRT_A, 8'h00, 8'hFF);
        // Every other step time: one code up, read at the last cycle
        // before the step and at the second one after it.
        for (int m = 1; m < 4; m++)
        begin
            st = (m == 1) ? S1 : (m == 2) ? S2 : S3;
            wr(LDC_ADDR_RAMP, 8'(m));
            wr(LDC_ADDR_BRT_A, 8'(m));
            rd(LDC_ADDR_STATUS, 8'(8'h40 + m - 1), 8'hFF);
            wait_cyc(st - 4);
            rd(LDC_ADDR_STATUS, 8'(8'h40 + m - 1), 8'hFF);
            rd(LDC_ADDR_STATUS, 8'(m), 8'hFF);
        end
        wait_cyc(3);
        test_done();
    end
endmodule
`default_nettype wire
